// >>> drs_defines.svh
/*
 * shared constants for the dram row/column strobe sequencer.
 * assumes inclusion by bare name from the same folder.
 */
`ifndef DRS_DEFINES_SVH
`define DRS_DEFINES_SVH

// ************************************************************
// geometry
// ************************************************************
`define DRS_CPU_ADDR_W 16
`define DRS_CELL_ADDR_W 14
`define DRS_HALF_ADDR_W 7
`define DRS_ROW_LSB 0
`define DRS_COL_LSB 7
`define DRS_SEL_BIT_LO 14
`define DRS_SEL_BIT_HI 15

// ************************************************************
// levels and timing
// ************************************************************
`define DRS_STROBE_IDLE 1'b1
`define DRS_STROBE_ACTIVE 1'b0
`define DRS_CLK_PERIOD_NS 20
`define DRS_CAS_DELAY_NS 10
`define DRS_CAS_DELAY_CYC (((`DRS_CAS_DELAY_NS) + (`DRS_CLK_PERIOD_NS) - 1) / (`DRS_CLK_PERIOD_NS))

`endif

// >>> drs_pkg.sv
/*
 * types for the dram row/column strobe sequencer.
 * assumes drs_defines.svh is reachable.
 */
`include "drs_defines.svh"
package drs_pkg;
    typedef enum logic [1:0] {
        drs_idle = 2'b00,
        drs_row = 2'b01,
        drs_col = 2'b11,
        drs_refresh_cycle_n = 2'b10
    } drs_phase_type;
endpackage

// >>> drs_sync.sv
/*
 * two flip-flop synchroniser for a bus of levels.
 * assumes an asynchronous active-high reset; reset value is a parameter.
 */
module drs_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // data
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            meta <= RESET_VALUE;
            sync_out <= RESET_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule

// >>> drs_sequencer.sv
/*
 * strobe sequencer for a 16k byte multiplexed-address dram bank.
 * assumes cpu bus strobes arrive asynchronously and are synchronised here;
 * dram data pins are joined to the cpu data bus outside, read data passed back.
 */
`include "drs_defines.svh"

// What this block does
// - the 16k byte bank answers only in the top quarter of the cpu address space.
// - with the mux select low the dram address carries the row half before row strobe falls.
// - a low on request or refresh passes two synchroniser stages and drives row strobe low at the third rising edge.
// - the bank is selected only when request is low and address bits 14 and 15 are high.
// - while selected a first clocked stage goes low and switches the mux to the column half.
// - column strobe comes from a second stage after the first so the column address settles.
// - with column strobe low the dram latches the column address on the mux outputs.
// - request returning high raises row strobe and presets both stages so column strobe rises.
// - while column strobe is low on a read the dram data of the latched address goes to the cpu data bus.
// - a low refresh drives row strobe low through the same stage with no column strobe.
// - row strobe rises only when refresh and request are both high.
// - write enable is low while write strobe and request are both low and the bank is selected.
// - a 14 bit cell address goes out as a 7 bit row part then a 7 bit column part.
// - the strobe stages run on the cpu clock.
module drs_sequencer (
    // clock and reset
    input wire logic clk_sys,
    input wire logic sys_rst,
    // cpu bus
    input wire logic memory_request_n,
    input wire logic refresh_cycle_n,
    input wire logic write_strobe_n,
    input wire logic [`DRS_CPU_ADDR_W-1:0] cpu_addr,
    input wire logic [7:0] dram_data_in,
    output logic [7:0] cpu_read_data,
    output logic cpu_read_valid,
    // dram array
    output logic [`DRS_HALF_ADDR_W-1:0] dram_addr,
    output logic row_strobe_n,
    output logic col_strobe_n,
    output logic write_enable_n,
    output logic mux_select
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    logic [2:0] strobes;
    logic memory_request_n_n;
    logic refresh_cycle_n_n;
    logic wr_n;
    logic [`DRS_CPU_ADDR_W-1:0] addr;

    drs_sync #(.WIDTH(3), .RESET_VALUE(3'h7)) u_sync_strobes (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in({memory_request_n, refresh_cycle_n, write_strobe_n}),
        .sync_out(strobes)
    );

    drs_sync #(.WIDTH(`DRS_CPU_ADDR_W), .RESET_VALUE(16'h0000)) u_sync_addr (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .async_in(cpu_addr),
        .sync_out(addr)
    );

    assign memory_request_n_n = strobes[2];
    assign refresh_cycle_n_n = strobes[1];
    assign wr_n = strobes[0];

    // ************************************************************
    // decode
    // ************************************************************
    function automatic logic bank_hit(input logic req_n, input logic [`DRS_CPU_ADDR_W-1:0] a);
        bank_hit = !req_n && a[`DRS_SEL_BIT_LO] && a[`DRS_SEL_BIT_HI];
    endfunction

    // high while the row stage holds the column stages preset
    function automatic logic stages_preset(input logic req_n, input logic ras_n);
        stages_preset = req_n || ras_n;
    endfunction

    logic select_n;
    logic row_req_n;
    logic stage1_n;
    drs_pkg::drs_phase_type phase;

    assign select_n = !(bank_hit(memory_request_n_n, addr) && refresh_cycle_n_n);
    assign row_req_n = memory_request_n_n && refresh_cycle_n_n;

    // ************************************************************
    // row strobe stage
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            row_strobe_n <= `DRS_STROBE_IDLE;
        end else begin
            row_strobe_n <= row_req_n;
        end
    end

    // ************************************************************
    // column stages, preset by the row stage
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            stage1_n <= `DRS_STROBE_IDLE;
            col_strobe_n <= `DRS_STROBE_IDLE;
            mux_select <= 1'b0;
        end else if (stages_preset(row_req_n, row_strobe_n)) begin
            stage1_n <= `DRS_STROBE_IDLE;
            col_strobe_n <= `DRS_STROBE_IDLE;
            mux_select <= 1'b0;
        end else begin
            stage1_n <= select_n;
            mux_select <= !select_n;
            col_strobe_n <= stage1_n;
        end
    end

    // ************************************************************
    // address multiplexer
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            dram_addr <= '0;
        end else if (stages_preset(row_req_n, row_strobe_n)) begin
            dram_addr <= addr[`DRS_ROW_LSB +: `DRS_HALF_ADDR_W];
        end else if (!select_n) begin
            dram_addr <= addr[`DRS_COL_LSB +: `DRS_HALF_ADDR_W];
        end
    end

    // ************************************************************
    // write enable
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            write_enable_n <= `DRS_STROBE_IDLE;
        end else begin
            write_enable_n <= !(!wr_n && !memory_request_n_n && refresh_cycle_n_n && !select_n);
        end
    end

    // ************************************************************
    // read return
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cpu_read_data <= 8'h00;
            cpu_read_valid <= 1'b0;
        end else begin
            cpu_read_valid <= 1'b0;
            if (!col_strobe_n && wr_n) begin
                cpu_read_data <= dram_data_in;
                cpu_read_valid <= !row_req_n;
            end
        end
    end

    // ************************************************************
    // phase tracking for coverage
    // ************************************************************
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= drs_pkg::drs_idle;
        end else begin
            case (phase)
                drs_pkg::drs_idle: begin
                    if (!row_req_n && !refresh_cycle_n_n) phase <= drs_pkg::drs_refresh_cycle_n;
                    else if (!row_req_n) phase <= drs_pkg::drs_row;
                end
                drs_pkg::drs_row: begin
                    if (row_req_n) phase <= drs_pkg::drs_idle;
                    else if (!col_strobe_n) phase <= drs_pkg::drs_col;
                end
                drs_pkg::drs_col: begin
                    if (row_req_n) phase <= drs_pkg::drs_idle;
                end
                drs_pkg::drs_refresh_cycle_n: begin
                    if (row_req_n) phase <= drs_pkg::drs_idle;
                end
                default: phase <= drs_pkg::drs_idle;
            endcase
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_row_follows;
        @(posedge clk_sys) disable iff (sys_rst) 1'b1 |=> row_strobe_n == $past(row_req_n);
    endproperty
    a_row_follows: assert property (p_row_follows) else $error("row strobe not one edge after request");

    property p_row_high_both;
        @(posedge clk_sys) disable iff (sys_rst) $rose(row_strobe_n) |-> $past(memory_request_n_n && refresh_cycle_n_n);
    endproperty
    a_row_high_both: assert property (p_row_high_both) else $error("row strobe rose with a request low");

    property p_cas_after_ras;
        @(posedge clk_sys) disable iff (sys_rst) !col_strobe_n |-> !row_strobe_n;
    endproperty
    a_cas_after_ras: assert property (p_cas_after_ras) else $error("column strobe low without row strobe");

    property p_cas_two_stage;
        @(posedge clk_sys) disable iff (sys_rst) $fell(col_strobe_n) |-> $past(!stage1_n) && $past(mux_select);
    endproperty
    a_cas_two_stage: assert property (p_cas_two_stage) else $error("column strobe fell before first stage");

    property p_no_cas_refresh;
        @(posedge clk_sys) disable iff (sys_rst) !refresh_cycle_n_n ##1 !refresh_cycle_n_n |-> col_strobe_n && write_enable_n;
    endproperty
    a_no_cas_refresh: assert property (p_no_cas_refresh) else $error("column strobe during refresh");

    property p_select_decode;
        @(posedge clk_sys) disable iff (sys_rst) !stage1_n |-> $past(bank_hit(memory_request_n_n, addr));
    endproperty
    a_select_decode: assert property (p_select_decode) else $error("first stage low outside the bank");

    property p_we;
        @(posedge clk_sys) disable iff (sys_rst) !write_enable_n |-> $past(!wr_n && !memory_request_n_n);
    endproperty
    a_we: assert property (p_we) else $error("write enable without write and request");

    property p_release;
        @(posedge clk_sys) disable iff (sys_rst) $rose(memory_request_n_n) && refresh_cycle_n_n |-> ##1 row_strobe_n ##1 col_strobe_n;
    endproperty
    a_release: assert property (p_release) else $error("strobes not released after request");

    property p_row_addr_idle;
        @(posedge clk_sys) disable iff (sys_rst)
            row_strobe_n && row_req_n
            |=> dram_addr == $past(addr[`DRS_ROW_LSB +: `DRS_HALF_ADDR_W]);
    endproperty
    a_row_addr_idle: assert property (p_row_addr_idle) else $error("row half not on dram address");

    property p_row_mux_low;
        @(posedge clk_sys) disable iff (sys_rst)
            $fell(row_strobe_n)
            |-> !mux_select;
    endproperty
    a_row_mux_low: assert property (p_row_mux_low) else $error("mux on column when row strobe fell");

    property p_col_addr;
        @(posedge clk_sys) disable iff (sys_rst)
            mux_select
            |-> dram_addr == $past(addr[`DRS_COL_LSB +: `DRS_HALF_ADDR_W]);
    endproperty
    a_col_addr: assert property (p_col_addr) else $error("column half not on dram address");

    property p_mux_stage1;
        @(posedge clk_sys) disable iff (sys_rst)
            1'b1
            |-> mux_select != stage1_n;
    endproperty
    a_mux_stage1: assert property (p_mux_stage1) else $error("mux select not tied to first stage");

    property p_preset;
        @(posedge clk_sys) disable iff (sys_rst)
            row_strobe_n
            |-> col_strobe_n && stage1_n && !mux_select;
    endproperty
    a_preset: assert property (p_preset) else $error("column stages not preset");

    property p_idle_no_we;
        @(posedge clk_sys) disable iff (sys_rst)
            row_strobe_n
            |-> write_enable_n;
    endproperty
    a_idle_no_we: assert property (p_idle_no_we) else $error("write enable without row strobe");

    property p_refresh_row;
        @(posedge clk_sys) disable iff (sys_rst)
            !refresh_cycle_n_n
            |=> !row_strobe_n;
    endproperty
    a_refresh_row: assert property (p_refresh_row) else $error("refresh gave no row strobe");

    property p_we_select;
        @(posedge clk_sys) disable iff (sys_rst)
            !write_enable_n
            |-> $past(!select_n);
    endproperty
    a_we_select: assert property (p_we_select) else $error("write enable outside the bank");

    property p_read_valid;
        @(posedge clk_sys) disable iff (sys_rst)
            cpu_read_valid
            |-> $past(!col_strobe_n && !row_req_n && wr_n);
    endproperty
    a_read_valid: assert property (p_read_valid) else $error("read valid outside a read");

    property p_read_data;
        @(posedge clk_sys) disable iff (sys_rst)
            cpu_read_valid
            |-> cpu_read_data == $past(dram_data_in);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read data not taken from dram");

    // ************************************************************
    // covers
    // ************************************************************
    c_read: cover property (@(posedge clk_sys) disable iff (sys_rst) $fell(col_strobe_n) && write_enable_n);
    c_write: cover property (@(posedge clk_sys) disable iff (sys_rst) !col_strobe_n && !write_enable_n);
    c_refresh: cover property (@(posedge clk_sys) disable iff (sys_rst) phase == drs_pkg::drs_refresh_cycle_n);
    c_outside: cover property (@(posedge clk_sys) disable iff (sys_rst) !row_strobe_n && !bank_hit(memory_request_n_n, addr));
    c_release: cover property (@(posedge clk_sys) disable iff (sys_rst) $rose(col_strobe_n));
endmodule

// >>> drs_dram_model.sv
/*
 * behavioural dram bank behind the strobe sequencer.
 * assumes strobes and the muxed address come from drs_sequencer.
 */
`include "drs_defines.svh"
module drs_dram_model (
    // clock
    input wire logic clk_sys,
    // dram pins
    input wire logic [`DRS_HALF_ADDR_W-1:0] dram_addr,
    input wire logic row_strobe_n,
    input wire logic col_strobe_n,
    input wire logic write_enable_n,
    input wire logic [7:0] write_data,
    output logic [7:0] dram_data_in,
    // latched halves
    output logic [`DRS_HALF_ADDR_W-1:0] row_seen,
    output logic [`DRS_HALF_ADDR_W-1:0] col_seen
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:16383];
    logic [7:0] junk = 8'h5a;
    always @(negedge row_strobe_n) row_seen <= dram_addr;
    always @(negedge col_strobe_n) col_seen <= dram_addr;
    always @(posedge clk_sys) begin
        junk <= junk + 8'h33;
        if (!row_strobe_n && !col_strobe_n && !write_enable_n) begin
            mem[{col_seen, row_seen}] <= write_data;
        end
    end
    // released data pins change every cycle
    assign dram_data_in = !col_strobe_n ? mem[{col_seen, row_seen}] : junk;
endmodule

// >>> dram_ras_cas_sequencer_tb.sv
/*
 * self-checking bench for drs_sequencer with a dram model.
 * assumes drs_dram_model.sv and the design files are compiled first.
 */
module dram_ras_cas_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic memory_request_n = 1'b1;
    logic refresh_cycle_n = 1'b1;
    logic write_strobe_n = 1'b1;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] write_data = 8'h00;
    logic [7:0] dram_data_in, cpu_read_data;
    logic [6:0] dram_addr, row_seen, col_seen;
    logic cpu_read_valid, row_strobe_n, col_strobe_n, write_enable_n, mux_select;
    logic [15:0] addrs [3] = '{16'hc000, 16'hffff, 16'hd2b4};
    int num_errors = 0;
    int n_compared = 0;
    int n;
    always #10 clk_sys = ~clk_sys;
    drs_sequencer DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .memory_request_n(memory_request_n),
        .refresh_cycle_n(refresh_cycle_n), .write_strobe_n(write_strobe_n), .cpu_addr(cpu_addr),
        .dram_data_in(dram_data_in), .cpu_read_data(cpu_read_data), .cpu_read_valid(cpu_read_valid),
        .dram_addr(dram_addr), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
        .write_enable_n(write_enable_n), .mux_select(mux_select));
    drs_dram_model model (.clk_sys(clk_sys), .dram_addr(dram_addr), .row_strobe_n(row_strobe_n),
        .col_strobe_n(col_strobe_n), .write_enable_n(write_enable_n), .write_data(write_data),
        .dram_data_in(dram_data_in), .row_seen(row_seen), .col_seen(col_seen));
    // ********************************************************
    // helpers
    // ********************************************************
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic pick(input int k);
        case (k)
            0: return row_strobe_n;
            1: return col_strobe_n;
            2: return write_enable_n;
            default: return cpu_read_valid;
        endcase
    endfunction
    // counts edges until the chosen output reaches v
    task automatic wait_for(input int k, input logic v);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (pick(k) !== v && n < 20);
        if (pick(k) !== v) begin
            check("wait", 16'(v), 16'(pick(k)));
            wrap_up();
        end
    endtask
    task automatic watch(input int c, input logic r);
        repeat (c) begin
            @(posedge clk_sys);
            #1;
            check("row hold", 16'(r), 16'(row_strobe_n));
            check("no column", 16'h1, 16'(col_strobe_n));
            check("no write", 16'h1, 16'(write_enable_n));
        end
    endtask
    // ********************************************************
    // scenarios
    // ********************************************************
    task automatic t_reset();
        repeat (10) @(posedge clk_sys);
        #1;
        check("reset strobes", 16'h7, 16'({row_strobe_n, col_strobe_n, write_enable_n}));
        check("reset mux", 16'h0, 16'(mux_select));
        @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_access(input logic [15:0] a, input logic wr);
        logic [7:0] d;
        d = a[7:0] ^ a[15:8] ^ 8'h5a;
        @(posedge clk_sys);
        cpu_addr <= a;
        write_data <= d;
        @(posedge clk_sys);
        memory_request_n <= 1'b0;
        wait_for(0, 1'b0);
        check("row delay", 16'd3, 16'(n));
        check("row half", 16'(a[6:0]), 16'(row_seen));
        wait_for(1, 1'b0);
        check("col delay", 16'd2, 16'(n));
        check("mux select", 16'h1, 16'(mux_select));
        check("col half", 16'(a[13:7]), 16'(col_seen));
        if (wr) begin
            @(posedge clk_sys);
            write_strobe_n <= 1'b0;
            wait_for(2, 1'b0);
            check("we delay", 16'd3, 16'(n));
            @(posedge clk_sys);
            write_strobe_n <= 1'b1;
            wait_for(2, 1'b1);
        end else begin
            wait_for(3, 1'b1);
            check("read valid delay", 16'd1, 16'(n));
            check("read data", 16'(d), 16'(cpu_read_data));
        end
        @(posedge clk_sys);
        memory_request_n <= 1'b1;
        wait_for(0, 1'b1);
        check("row release", 16'd3, 16'(n));
        check("col release", 16'h1, 16'(col_strobe_n));
        check("mux release", 16'h0, 16'(mux_select));
        check("addr idle", 16'(a[6:0]), 16'(dram_addr));
    endtask
    task automatic t_outside(input logic [15:0] a);
        @(posedge clk_sys);
        cpu_addr <= a;
        memory_request_n <= 1'b0;
        wait_for(0, 1'b0);
        @(posedge clk_sys);
        write_strobe_n <= 1'b0;
        watch(8, 1'b0);
        @(posedge clk_sys);
        memory_request_n <= 1'b1;
        write_strobe_n <= 1'b1;
        wait_for(0, 1'b1);
    endtask
    task automatic t_refresh();
        @(posedge clk_sys);
        cpu_addr <= 16'hc0a5;
        refresh_cycle_n <= 1'b0;
        memory_request_n <= 1'b0;
        wait_for(0, 1'b0);
        check("refresh row", 16'd3, 16'(n));
        @(posedge clk_sys);
        write_strobe_n <= 1'b0;
        watch(6, 1'b0);
        @(posedge clk_sys);
        memory_request_n <= 1'b1;
        write_strobe_n <= 1'b1;
        watch(6, 1'b0);
        @(posedge clk_sys);
        refresh_cycle_n <= 1'b1;
        wait_for(0, 1'b1);
        check("refresh release", 16'd3, 16'(n));
    endtask
    initial begin
        t_reset();
        foreach (addrs[i]) t_access(addrs[i], 1'b1);
        foreach (addrs[i]) t_access(addrs[i], 1'b0);
        t_outside(16'hbfff);
        t_outside(16'h7fff);
        t_refresh();
        wrap_up();
    end
endmodule
